// ---- include/cmfc_pkg.sv ----
// Constants and carrier types of the charger mode and fault controller
// ----------------------------------------------------------------------------
// Functional notes
// - Flag hold-loop limiting; ramp current slowly up to limit or hold point.
// - Decode 3-bit hold threshold code into eight equal rising voltage steps.
// - At foldback temperature cap charge output current at 550 mA.
// - Above trip temperature suspend charging, fault 101, pulse status pin.
// - In thermal suspend freeze timers and state; resume once cooled.
// - Input between minimum and battery+offset: sleep and block reverse current.
// - Input below minimum while charging: stop, pulse pin, state 11, fault 011.
// - After low-input stop, retry only if input recovered after two seconds.
// - Input over-voltage: open input transistor, suspend, fault 001, state 11.
// - Clear over-voltage below hysteresis level; resume only after revalidation.
// - No switching pulses for 30 ms: fault 100, state 11, pulse pin.
// - Termination near float: state 10, discharge for detect time, present 000.
// - Battery below presence level after discharge: no-battery mode, fault 111.
// - Below short threshold charge only from linear precharge source.
// - No battery: keep charging; exit on power reconnect or enable toggle.
// - Status pin open idle, low while charging if enabled, 2 Hz on fault.
// - Fault codes 000,001,010,011,100,101,111; code 110 unused.
// - Charge only when disable pin, inhibit and high-impedance bits are 0.
// - Mode: pin boost, else high-impedance, else no-charge on fault, else register boost, else charge.
// - Boost request pin active high if polarity bit 1, else active low.
// - Pin-requested boost starts even with high-impedance bit set.
// - Register-requested boost only while high-impedance bit is 0.
// - After termination show state 00 for 30 ms, then 10.
// - Input must stay valid 30 ms before any charge start or restart.
// ----------------------------------------------------------------------------
package cmfc_pkg;

    // ------------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int CYC_PER_MS     = CLK_HZ / 1000;
    localparam int T_VALID_MS     = 30;
    localparam int T_TERM_MS      = 30;
    localparam int T_BOVP_MS      = 30;
    localparam int T_RETRY_MS     = 2000;
    localparam int T_DETECT_MS    = 10;
    localparam int T_RAMP_US      = 100;
    localparam int BLINK_HZ       = 2;
    localparam int CYC_VALID      = T_VALID_MS * CYC_PER_MS;
    localparam int CYC_TERM       = T_TERM_MS * CYC_PER_MS;
    localparam int CYC_BOVP       = T_BOVP_MS * CYC_PER_MS;
    localparam int CYC_RETRY      = T_RETRY_MS * CYC_PER_MS;
    localparam int CYC_DETECT     = T_DETECT_MS * CYC_PER_MS;
    localparam int CYC_RAMP       = T_RAMP_US * (CLK_HZ / 1_000_000);
    localparam int CYC_BLINK_HALF = CLK_HZ / (2 * BLINK_HZ);
    localparam int TMR_W          = 27;

    // ------------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------------
    localparam logic [2:0]  FC_NONE    = 3'h0;
    localparam logic [2:0]  FC_OVP     = 3'h1;
    localparam logic [2:0]  FC_SLEEP   = 3'h2;
    localparam logic [2:0]  FC_LOWIN   = 3'h3;
    localparam logic [2:0]  FC_BATOVP  = 3'h4;
    localparam logic [2:0]  FC_THERMAL = 3'h5;
    localparam logic [2:0]  FC_NOBAT   = 3'h7;
    localparam logic [1:0]  CS_READY   = 2'h0;
    localparam logic [1:0]  CS_CHARGE  = 2'h1;
    localparam logic [1:0]  CS_DONE    = 2'h2;
    localparam logic [1:0]  CS_FAULT   = 2'h3;
    localparam logic [12:0] HOLD_BASE_MV = 13'h1081;
    localparam logic [12:0] HOLD_STEP_MV = 13'h004B;
    localparam logic [9:0]  FOLDBACK_MA  = 10'h226;

    typedef enum logic [6:0] {
        ST_VALIDATE = 7'b0000001,
        ST_CHARGE   = 7'b0000010,
        ST_TERM     = 7'b0000100,
        ST_DETECT   = 7'b0001000,
        ST_DONE     = 7'b0010000,
        ST_LOWIN    = 7'b0100000,
        ST_NOBAT    = 7'b1000000
    } cmfc_state_t;

    typedef enum logic [3:0] {
        MODE_CHARGE = 4'b0001,
        MODE_NOCHG  = 4'b0010,
        MODE_BOOST  = 4'b0100,
        MODE_HIZ    = 4'b1000
    } cmfc_mode_t;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic vbus_above_min;
        logic vbus_over_ovp;
        logic vbus_below_ovp_hyst;
        logic vbus_below_sleep;
        logic die_over_foldback;
        logic die_over_trip;
        logic bat_below_short;
        logic bat_above_presence;
        logic term_current;
        logic near_float;
        logic pwm_pulse;
        logic hold_loop_limiting;
        logic current_limit_reached;
    } cmfc_sense_t;

    typedef struct packed {
        logic       disable_pin;
        logic       charge_inhibit_bit;
        logic       high_impedance_bit;
        logic       boost_request_bit;
        logic       otg_pin_enable_bit;
        logic       otg_pin_polarity_bit;
        logic       otg_pin;
        logic       status_pin_enable_bit;
        logic       termination_enable_bit;
        logic       active_low_enable_pin;
        logic [2:0] vbus_hold_threshold;
        logic [2:0] charge_current_limit;
    } cmfc_ctrl_t;

    typedef struct packed {
        logic [2:0]  fault_code;
        logic [1:0]  charge_state_field;
        cmfc_mode_t  mode;
        logic        vbus_hold_active_flag;
        logic [12:0] hold_threshold_mv;
        logic [2:0]  ramp_level;
        logic [9:0]  current_cap_ma;
        logic        charge_enable;
        logic        foldback_active;
        logic        precharge_enable;
        logic        pwm_enable;
        logic        input_blocking_on;
        logic        reverse_block_on;
        logic        detect_discharge_on;
        logic        boost_enable;
        logic        no_battery_mode;
    } cmfc_status_t;

    typedef struct packed {
        cmfc_state_t  fsm;
        logic         susp;
        logic         ovp;
        logic         lowin;
        logic         bovp;
        logic         enn_prev;
        logic         blink;
        logic         pin_oe;
        cmfc_status_t status;
    } cmfc_core_t;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic             hit;
    } cmfc_tmr_t;

endpackage

// ---- hdl/cmfc_cycle_timer.sv ----
// Cycle counter used for timeouts and rate dividers
`timescale 1ns/10ps
`default_nettype none
module cmfc_cycle_timer #(
    parameter bit RELOAD = 1'b0
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      run,
    input  wire logic                      clr,
    input  wire logic [cmfc_pkg::TMR_W-1:0] limit,
    output logic                           hit
);
    import cmfc_pkg::*;

    cmfc_tmr_t q;
    cmfc_tmr_t next_q;

    // Saturating mode holds hit until clr; reload mode gives one-cycle ticks
    always_comb begin
        next_q = q;
        if (RELOAD) begin
            next_q.hit = 1'b0;
        end
        if (clr) begin
            next_q = '0;
        end else if (run) begin
            if (q.cnt >= limit - 1'b1) begin
                next_q.hit = 1'b1;
                if (RELOAD) begin
                    next_q.cnt = '0;
                end
            end else begin
                next_q.cnt = q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign hit = q.hit;
endmodule // cmfc_cycle_timer
`default_nettype wire

// ---- hdl/cmfc_charger_ctrl.sv ----
// Supervisory mode, fault and status-pin logic of the charger
`timescale 1ns/10ps
`default_nettype none
module cmfc_charger_ctrl #(
    parameter int CYC_VALID_P  = cmfc_pkg::CYC_VALID,
    parameter int CYC_TERM_P   = cmfc_pkg::CYC_TERM,
    parameter int CYC_BOVP_P   = cmfc_pkg::CYC_BOVP,
    parameter int CYC_RETRY_P  = cmfc_pkg::CYC_RETRY,
    parameter int CYC_DETECT_P = cmfc_pkg::CYC_DETECT,
    parameter int CYC_RAMP_P   = cmfc_pkg::CYC_RAMP,
    parameter int CYC_BLINK_P  = cmfc_pkg::CYC_BLINK_HALF
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire cmfc_pkg::cmfc_sense_t sense,
    input  wire cmfc_pkg::cmfc_ctrl_t  ctrl,
    output cmfc_pkg::cmfc_status_t     status,
    output logic                      status_pin_o,
    output logic                      status_pin_oe
);
    import cmfc_pkg::*;

    cmfc_core_t       q;
    cmfc_core_t       next_q;
    logic             chg_ok;
    logic             pin_boost;
    logic             reg_boost;
    logic             sleep;
    logic             fault_block;
    logic             st_hit;
    logic             st_clr;
    logic [TMR_W-1:0] st_limit;
    logic             bovp_hit;
    logic             ramp_tick;
    logic             blink_tick;

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------
    // One timer serves every state wait; it freezes during thermal suspend
    always_comb begin
        case (q.fsm)
            ST_TERM:   st_limit = TMR_W'(CYC_TERM_P);
            ST_DETECT: st_limit = TMR_W'(CYC_DETECT_P);
            ST_LOWIN:  st_limit = TMR_W'(CYC_RETRY_P);
            default:   st_limit = TMR_W'(CYC_VALID_P);
        endcase
    end

    assign st_clr = (next_q.fsm != q.fsm) ||
                    (q.fsm == ST_VALIDATE &&
                     !(sense.vbus_above_min && !sense.vbus_over_ovp &&
                       !q.ovp));

    cmfc_cycle_timer #(.RELOAD(1'b0)) u_state_tmr (
        .clk   (clk),
        .nrst  (nrst),
        .run   (!q.susp),
        .clr   (st_clr),
        .limit (st_limit),
        .hit   (st_hit)
    );

    cmfc_cycle_timer #(.RELOAD(1'b0)) u_bovp_tmr (
        .clk   (clk),
        .nrst  (nrst),
        .run   (q.status.pwm_enable && !q.susp),
        .clr   (sense.pwm_pulse || q.fsm != ST_CHARGE),
        .limit (TMR_W'(CYC_BOVP_P)),
        .hit   (bovp_hit)
    );

    cmfc_cycle_timer #(.RELOAD(1'b1)) u_ramp_div (
        .clk   (clk),
        .nrst  (nrst),
        .run   (q.status.charge_enable),
        .clr   (!q.status.charge_enable),
        .limit (TMR_W'(CYC_RAMP_P)),
        .hit   (ramp_tick)
    );

    cmfc_cycle_timer #(.RELOAD(1'b1)) u_blink_div (
        .clk   (clk),
        .nrst  (nrst),
        .run   (q.status.fault_code != FC_NONE),
        .clr   (q.status.fault_code == FC_NONE),
        .limit (TMR_W'(CYC_BLINK_P)),
        .hit   (blink_tick)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_q = q;
        chg_ok = !ctrl.disable_pin && !ctrl.charge_inhibit_bit &&
                 !ctrl.high_impedance_bit;
        pin_boost = ctrl.otg_pin_enable_bit &&
                    (ctrl.otg_pin == ctrl.otg_pin_polarity_bit);
        reg_boost = ctrl.boost_request_bit &&
                    !ctrl.high_impedance_bit;
        sleep = sense.vbus_above_min && sense.vbus_below_sleep;
        next_q.enn_prev = ctrl.active_low_enable_pin;

        // Sticky fault flags; a set in the same cycle beats the clear
        if (sense.die_over_trip) begin
            next_q.susp = 1'b1;
        end else if (!sense.die_over_foldback) begin
            next_q.susp = 1'b0;
        end
        if (sense.vbus_over_ovp) begin
            next_q.ovp = 1'b1;
        end else if (sense.vbus_below_ovp_hyst) begin
            next_q.ovp = 1'b0;
        end
        if (bovp_hit) begin
            next_q.bovp = 1'b1;
        end else if (!chg_ok || q.fsm != ST_CHARGE) begin
            next_q.bovp = 1'b0;
        end

        // Sequencer; the enable bits and boost pre-empt even a suspend
        if (!chg_ok || pin_boost || reg_boost) begin
            next_q.fsm   = ST_VALIDATE;
            next_q.lowin = 1'b0;
        end else if (q.susp) begin
            next_q.fsm = q.fsm;
        end else if (next_q.ovp) begin
            next_q.fsm = ST_VALIDATE;
        end else begin
            case (q.fsm)
                ST_VALIDATE: begin
                    if (st_hit) begin
                        next_q.fsm = ST_CHARGE;
                    end
                end
                ST_CHARGE: begin
                    if (!sense.vbus_above_min) begin
                        next_q.fsm   = ST_LOWIN;
                        next_q.lowin = 1'b1;
                    end else if (ctrl.termination_enable_bit &&
                                 sense.term_current && sense.near_float) begin
                        next_q.fsm = ST_TERM;
                    end
                end
                ST_TERM: begin
                    if (st_hit) begin
                        next_q.fsm = ST_DETECT;
                    end
                end
                ST_DETECT: begin
                    if (st_hit) begin
                        next_q.fsm = sense.bat_above_presence ?
                                     ST_DONE : ST_NOBAT;
                    end
                end
                ST_LOWIN: begin
                    if (st_hit && sense.vbus_above_min) begin
                        next_q.fsm   = ST_VALIDATE;
                        next_q.lowin = 1'b0;
                    end
                end
                ST_NOBAT: begin
                    if (!sense.vbus_above_min ||
                        ctrl.active_low_enable_pin != q.enn_prev) begin
                        next_q.fsm = ST_VALIDATE;
                    end
                end
                ST_DONE: next_q.fsm = ST_DONE;
                default: next_q.fsm = ST_VALIDATE;
            endcase
        end

        // Fault code by fixed priority
        if (next_q.susp) begin
            next_q.status.fault_code = FC_THERMAL;
        end else if (next_q.ovp) begin
            next_q.status.fault_code = FC_OVP;
        end else if (next_q.lowin) begin
            next_q.status.fault_code = FC_LOWIN;
        end else if (next_q.bovp) begin
            next_q.status.fault_code = FC_BATOVP;
        end else if (sleep) begin
            next_q.status.fault_code = FC_SLEEP;
        end else if (next_q.fsm == ST_NOBAT) begin
            next_q.status.fault_code = FC_NOBAT;
        end else begin
            next_q.status.fault_code = FC_NONE;
        end
        // No battery still charges, so it does not block the charger
        fault_block = next_q.status.fault_code != FC_NONE &&
                      next_q.status.fault_code != FC_NOBAT;

        if (next_q.ovp || next_q.lowin || next_q.bovp) begin
            next_q.status.charge_state_field = CS_FAULT;
        end else begin
            case (next_q.fsm)
                ST_CHARGE, ST_NOBAT:
                    next_q.status.charge_state_field = CS_CHARGE;
                ST_DETECT, ST_DONE:
                    next_q.status.charge_state_field = CS_DONE;
                default:
                    next_q.status.charge_state_field = CS_READY;
            endcase
        end

        if (pin_boost) begin
            next_q.status.mode = MODE_BOOST;
        end else if (!chg_ok) begin
            next_q.status.mode = MODE_HIZ;
        end else if (fault_block) begin
            next_q.status.mode = MODE_NOCHG;
        end else if (reg_boost) begin
            next_q.status.mode = MODE_BOOST;
        end else begin
            next_q.status.mode = MODE_CHARGE;
        end

        next_q.status.boost_enable = next_q.status.mode == MODE_BOOST;
        next_q.status.charge_enable = next_q.status.mode == MODE_CHARGE &&
            (next_q.fsm == ST_CHARGE || next_q.fsm == ST_NOBAT) &&
            !next_q.susp;
        next_q.status.no_battery_mode = next_q.fsm == ST_NOBAT;
        next_q.status.precharge_enable = next_q.status.charge_enable &&
                                         sense.bat_below_short;
        next_q.status.pwm_enable = next_q.status.charge_enable &&
                                   !sense.bat_below_short;
        next_q.status.foldback_active = next_q.status.charge_enable &&
                                        sense.die_over_foldback;
        next_q.status.current_cap_ma = next_q.status.foldback_active ?
                                       FOLDBACK_MA : '0;
        next_q.status.input_blocking_on = !next_q.ovp;
        next_q.status.reverse_block_on = sleep ||
                                         next_q.status.mode == MODE_HIZ;
        next_q.status.detect_discharge_on = next_q.fsm == ST_DETECT &&
                                            !next_q.susp;
        next_q.status.vbus_hold_active_flag = next_q.status.charge_enable &&
                                              sense.hold_loop_limiting;
        next_q.status.hold_threshold_mv = HOLD_BASE_MV +
            13'(ctrl.vbus_hold_threshold) * HOLD_STEP_MV;

        // Slow ramp stops at the programmed limit or at the hold point
        if (!next_q.status.charge_enable) begin
            next_q.status.ramp_level = '0;
        end else if (ramp_tick && !sense.hold_loop_limiting &&
                     !sense.current_limit_reached &&
                     q.status.ramp_level < ctrl.charge_current_limit) begin
            next_q.status.ramp_level = q.status.ramp_level + 1'b1;
        end

        // Open drain: released idle, pulled low while charging, blinks on fault
        if (next_q.status.fault_code == FC_NONE) begin
            next_q.blink  = 1'b0;
            next_q.pin_oe = next_q.status.charge_enable &&
                            ctrl.status_pin_enable_bit;
        end else begin
            next_q.blink  = blink_tick ? !q.blink : q.blink;
            next_q.pin_oe = next_q.blink;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q                 <= '0;
            q.fsm             <= ST_VALIDATE;
            q.enn_prev        <= 1'b1;
            q.status.mode     <= MODE_CHARGE;
        end else begin
            q <= next_q;
        end
    end

    assign status        = q.status;
    assign status_pin_o  = 1'b0;
    assign status_pin_oe = q.pin_oe;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_THERM_CODE: assert property (
        sense.die_over_trip |=> status.fault_code == FC_THERMAL &&
                                !status.charge_enable)
        else $error("thermal trip did not report fault 101");
    AST_OVP_FIELDS: assert property (
        (sense.vbus_over_ovp && !sense.die_over_trip && !q.susp) |=>
        status.fault_code == FC_OVP && status.charge_state_field == CS_FAULT
        && !status.input_blocking_on)
        else $error("input over-voltage fields wrong");
    AST_HIZ_MODE: assert property (
        (ctrl.high_impedance_bit && !pin_boost) |=> status.mode == MODE_HIZ)
        else $error("high-impedance bit did not select high impedance");
    AST_PIN_BOOST: assert property (
        pin_boost |=> status.mode == MODE_BOOST)
        else $error("pin boost request not honoured");
    AST_DISABLED: assert property (
        !chg_ok |=> !status.charge_enable && !status.pwm_enable)
        else $error("charging while disabled");
    AST_SUSP_FREEZE: assert property (
        (q.susp && !sense.vbus_over_ovp && chg_ok && !pin_boost
         && !reg_boost) |=> $stable(q.fsm))
        else $error("sequencer moved during thermal suspend");
    AST_LOW_INPUT: assert property (
        (q.fsm == ST_CHARGE && !sense.vbus_above_min && chg_ok && !pin_boost
         && !reg_boost && !q.susp && !q.ovp && !sense.vbus_over_ovp) |=>
        q.fsm == ST_LOWIN && status.charge_state_field == CS_FAULT)
        else $error("low input not handled");
    AST_VALID_ENTRY: assert property (
        $rose(q.fsm == ST_CHARGE) |-> $past(st_hit) &&
                                     $past(q.fsm) == ST_VALIDATE)
        else $error("charge started without validation");
    AST_PIN_IDLE: assert property (
        (status.fault_code == FC_NONE && !status.charge_enable) |->
        !status_pin_oe)
        else $error("status pin driven while idle");
endmodule // cmfc_charger_ctrl
`default_nettype wire

// ---- testbench/cmfc_host_model.sv ----
// Host-side view of the open-drain status pin
`timescale 1ns/10ps
`default_nettype none
module cmfc_host_model (
    input  wire logic status_pin_o,
    input  wire logic status_pin_oe,
    output logic      pin_level
);
    // Pull-up holds the line high whenever the device lets go
    assign pin_level = status_pin_oe ? status_pin_o : 1'b1;
endmodule // cmfc_host_model
`default_nettype wire

// ---- testbench/cmfc_charger_ctrl_tb.sv ----
// Self-checking bench of the charger mode and fault controller
`timescale 1ns/10ps
`default_nettype none
module cmfc_charger_ctrl_tb;
    import cmfc_pkg::*;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    cmfc_sense_t  sense = '0;
    cmfc_ctrl_t   ctrl = '0;
    cmfc_status_t st;
    logic         pin_o;
    logic         pin_oe;
    logic         pin;
    int           err_total = 0;
    int           n_tests = 0;
    always #10 clk = ~clk;
    // Short timer counts keep the run brief
    cmfc_charger_ctrl #(.CYC_VALID_P(8), .CYC_TERM_P(8), .CYC_BOVP_P(8),
        .CYC_DETECT_P(8), .CYC_BLINK_P(4))
    cmfc_charger_ctrl_i (.clk(clk), .nrst(nrst), .sense(sense),
        .ctrl(ctrl), .status(st), .status_pin_o(pin_o),
        .status_pin_oe(pin_oe));
    cmfc_host_model cmfc_host_model_i (.status_pin_o(pin_o),
        .status_pin_oe(pin_oe), .pin_level(pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rst_all(input cmfc_ctrl_t c);
        @(posedge clk);
        nrst <= 1'b0;
        sense <= '0;
        ctrl <= c;
        cyc(5);
        chk(st.fault_code, FC_NONE);
        chk(st.mode, MODE_CHARGE);
        @(posedge clk);
        nrst <= 1'b1;
        sense.vbus_above_min <= 1'b1;
    endtask
    task automatic t_hold();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ctrl.vbus_hold_threshold <= 3'(i);
            cyc(2);
            chk(st.hold_threshold_mv, 16'(4225 + 75 * i));
        end
    endtask
    task automatic t_mode(input logic [4:0] b, input cmfc_mode_t m);
        cmfc_ctrl_t c;
        c = '0;
        {c.high_impedance_bit, c.boost_request_bit, c.otg_pin_enable_bit,
            c.otg_pin_polarity_bit, c.otg_pin} = b;
        @(posedge clk);
        ctrl <= c;
        cyc(2);
        chk(st.mode, m);
        chk(st.boost_enable, m == MODE_BOOST);
        chk(st.charge_enable, 1'b0);
    endtask
    task automatic go_chg(input cmfc_ctrl_t c);
        int n;
        rst_all(c);
        cyc(4);
        chk(st.charge_enable, 1'b0);
        n = 0;
        while (st.charge_enable !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(st.charge_state_field, CS_CHARGE);
    endtask
    task automatic t_charge();
        cmfc_ctrl_t c;
        logic lv;
        int n;
        c = '0;
        c.status_pin_enable_bit = 1'b1;
        go_chg(c);
        chk(pin, 1'b0);
        chk(st.pwm_enable, 1'b1);
        @(posedge clk);
        sense.die_over_foldback <= 1'b1;
        sense.hold_loop_limiting <= 1'b1;
        sense.bat_below_short <= 1'b1;
        cyc(2);
        chk(st.current_cap_ma, FOLDBACK_MA);
        chk(st.vbus_hold_active_flag, 1'b1);
        chk(st.precharge_enable, 1'b1);
        @(posedge clk);
        sense.die_over_trip <= 1'b1;
        cyc(2);
        chk(st.fault_code, FC_THERMAL);
        chk(st.mode, MODE_NOCHG);
        chk(st.charge_enable, 1'b0);
        lv = pin;
        n = 0;
        repeat (16) begin
            cyc(1);
            if (pin !== lv) n++;
            lv = pin;
        end
        chk(n >= 3, 1'b1);
    endtask
    task automatic t_ovp();
        rst_all('0);
        @(posedge clk);
        sense.vbus_over_ovp <= 1'b1;
        cyc(2);
        chk(st.fault_code, FC_OVP);
        chk(st.charge_state_field, CS_FAULT);
        chk(st.input_blocking_on, 1'b0);
        @(posedge clk);
        sense.die_over_trip <= 1'b1;
        cyc(2);
        chk(st.fault_code, FC_THERMAL);
        @(posedge clk);
        sense.die_over_trip <= 1'b0;
        sense.vbus_over_ovp <= 1'b0;
        sense.vbus_below_ovp_hyst <= 1'b1;
        cyc(2);
        chk(st.fault_code, FC_NONE);
        cyc(3);
        chk(st.charge_enable, 1'b0);
        cyc(8);
        chk(st.charge_enable, 1'b1);
    endtask
    task automatic t_bovp();
        go_chg('0);
        @(posedge clk);
        sense.pwm_pulse <= 1'b1;
        @(posedge clk);
        sense.pwm_pulse <= 1'b0;
        cyc(8);
        chk(st.fault_code, FC_NONE);
        cyc(3);
        chk(st.fault_code, FC_BATOVP);
        chk(st.charge_state_field, CS_FAULT);
    endtask
    task automatic t_input();
        go_chg('0);
        @(posedge clk);
        sense.vbus_below_sleep <= 1'b1;
        cyc(2);
        chk(st.fault_code, FC_SLEEP);
        chk(st.reverse_block_on, 1'b1);
        @(posedge clk);
        sense.vbus_below_sleep <= 1'b0;
        sense.vbus_above_min <= 1'b0;
        cyc(2);
        chk(st.fault_code, FC_LOWIN);
        chk(st.charge_state_field, CS_FAULT);
        chk(st.charge_enable, 1'b0);
    endtask
    task automatic t_term(input logic present);
        cmfc_ctrl_t c;
        c = '0;
        c.termination_enable_bit = 1'b1;
        go_chg(c);
        @(posedge clk);
        sense.term_current <= 1'b1;
        sense.near_float <= 1'b1;
        sense.bat_above_presence <= present;
        cyc(2);
        chk(st.charge_state_field, CS_READY);
        chk(st.charge_enable, 1'b0);
        cyc(9);
        chk(st.charge_state_field, CS_DONE);
        chk(st.detect_discharge_on, 1'b1);
        cyc(10);
        chk(st.fault_code, present ? FC_NONE : FC_NOBAT);
        chk(st.no_battery_mode, !present);
        chk(st.charge_enable, !present);
        @(posedge clk);
        ctrl.active_low_enable_pin <= 1'b1;
        cyc(2);
        chk(st.no_battery_mode, 1'b0);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100us;
        err_total++;
        results();
    end
    initial begin
        rst_all('0);
        t_hold();
        t_mode(5'b10000, MODE_HIZ);
        t_mode(5'b01000, MODE_BOOST);
        t_mode(5'b11000, MODE_HIZ);
        t_mode(5'b10111, MODE_BOOST);
        t_mode(5'b10100, MODE_BOOST);
        t_mode(5'b10110, MODE_HIZ);
        t_charge();
        t_term(1'b1);
        t_term(1'b0);
        t_input();
        t_bovp();
        t_ovp();
        results();
    end
endmodule // cmfc_charger_ctrl_tb
`default_nettype wire
